// File: include/ads_pkg.sv
// ****************************************************************
// Shared constants and carriers of the auto-dialer number store
// ****************************************************************
package ads_pkg;

    // Store geometry: ports 01..58, ten digit memories, sixteen bins
    localparam logic [5:0] ADS_PORT_FIRST = 6'h01;
    localparam logic [5:0] ADS_PORT_LAST = 6'h3A;
    localparam int ADS_STORE_DEPTH = 32'h0000_4000;

    // Blank marker: the star key code is stored as the blank itself
    localparam logic [3:0] ADS_BLANK_CODE = 4'hB;

    // Counter ranges of the select chain
    localparam logic [3:0] ADS_BIN_FIRST = 4'h0;
    localparam logic [3:0] ADS_BIN_LAST = 4'hF;
    localparam logic [3:0] ADS_MEM_FIRST = 4'h1;
    localparam logic [3:0] ADS_MEM_LAST = 4'hA;
    localparam logic [3:0] ADS_ALT_OFFSET = 4'h5;
    localparam logic [3:0] ADS_UNITS_FIRST = 4'h0;
    localparam logic [3:0] ADS_UNITS_LAST = 4'h9;
    localparam logic [3:0] ADS_TENS_FIRST = 4'h0;
    localparam logic [3:0] ADS_TENS_LAST = 4'h5;

    // Bins that outpulsing may send; first and last are never sent, whatever they hold
    localparam logic [3:0] ADS_DIAL_BIN_FIRST = 4'h1;
    localparam logic [3:0] ADS_DIAL_BIN_LAST = 4'hE;
    localparam logic [2:0] ADS_PATTERNS = 3'h5;

    // Control code that stops all dialers, two BCD digits 8 and 5
    localparam logic [7:0] ADS_STOP_CODE = 8'h85;

    // Timing: 50 MHz clock, retry after 20 s of silence
    localparam int ADS_CLK_HZ = 32'h02FA_F080;
    localparam int ADS_RETRY_S = 32'h0000_0014;

    // Segment pattern of a dark readout
    localparam logic [6:0] ADS_SEG_DARK = 7'h00;

    // Edge-detected buttons and strobes
    typedef struct packed {
        logic power;
        logic reset;
        logic bin;
        logic mem;
        logic tens;
        logic units;
        logic key;
        logic tw_prog;
        logic tw_write;
        logic dial_go;
        logic ctl;
        logic done;
    } ads_btn_t;

    // Level inputs taken from the pins
    typedef struct packed {
        logic [3:0] key_code;
        logic variant;
        logic blank;
        logic [3:0] tw_tens;
        logic [3:0] tw_units;
        logic [3:0] tw_chip;
        logic [3:0] tw_addr;
        logic [5:0] dport;
        logic [2:0] pattern;
        logic alternate_number_set;
        logic [4:0] grounded;
        logic [7:0] ctl_code;
    } ads_lvl_t;

    // Select chain: bin, memory, port tens, port units
    typedef struct packed {
        logic [3:0] bin;
        logic [3:0] mem;
        logic [3:0] tens;
        logic [3:0] units;
    } ads_sel_t;

    typedef enum logic [2:0] {
        ADS_DIAL_IDLE = 3'b000,
        ADS_DIAL_SEIZE = 3'b001,
        ADS_DIAL_SCAN = 3'b010,
        ADS_DIAL_WAIT = 3'b011,
        ADS_DIAL_HOLD = 3'b100
    } ads_dial_st_t;

endpackage

// File: design/ads_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-stage synchroniser for pins
// ****************************************************************
module ads_sync #(
    parameter int W = 1
) (
    // Clocking
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Pins and result
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stage;
    } ads_sync_st_t;

    ads_sync_st_t q;
    ads_sync_st_t d;

    // Meta stage feeds only the second stage
    always_comb
    begin
        d = q;
        d.meta = pin_in;
        d.stage = q.meta;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign sync_q = q.stage;
endmodule

// File: design/ads_hex_seg.sv
`timescale 1ns/1ps
// ****************************************************************
// Registered hexadecimal readout driver
// ****************************************************************
module ads_hex_seg (
    // Clocking
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Value to show
    input wire logic [3:0] value,
    input wire logic dark,
    // Segments gfedcba, high lit
    output logic [6:0] seg_q
);
    typedef struct packed {
        logic [6:0] seg;
    } ads_seg_st_t;

    ads_seg_st_t q;
    ads_seg_st_t d;

    // Counts 10..15 show as letters A..F
    always_comb
    begin
        d = q;
        case (value)
            4'h0: d.seg = 7'h3F;
            4'h1: d.seg = 7'h06;
            4'h2: d.seg = 7'h5B;
            4'h3: d.seg = 7'h4F;
            4'h4: d.seg = 7'h66;
            4'h5: d.seg = 7'h6D;
            4'h6: d.seg = 7'h7D;
            4'h7: d.seg = 7'h07;
            4'h8: d.seg = 7'h7F;
            4'h9: d.seg = 7'h6F;
            4'hA: d.seg = 7'h77;
            4'hB: d.seg = 7'h7C;
            4'hC: d.seg = 7'h39;
            4'hD: d.seg = 7'h5E;
            4'hE: d.seg = 7'h79;
            default: d.seg = 7'h71;
        endcase
        if (dark)
            d.seg = ads_pkg::ADS_SEG_DARK;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            q.seg <= ads_pkg::ADS_SEG_DARK;
        else if (ce)
            q <= d;
    end

    assign seg_q = q.seg;
endmodule

// File: design/ads_number_store.sv
`timescale 1ns/1ps
module ads_number_store #(
    parameter int RETRY_CYCLES = ads_pkg::ADS_RETRY_S * ads_pkg::ADS_CLK_HZ
) (
    // Clocking
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Programmer panel
    input wire logic power_switch,
    input wire logic master_reset_button,
    input wire logic bin_button,
    input wire logic memory_select_button,
    input wire logic port_tens_button,
    input wire logic port_units_button,
    input wire logic key_strobe,
    input wire logic [3:0] key_code,
    // Thumbwheel programmer
    input wire logic thumbwheel_variant,
    input wire logic program_switch,
    input wire logic write_switch,
    input wire logic blank_key,
    input wire logic [3:0] tw_port_tens,
    input wire logic [3:0] tw_port_units,
    input wire logic [3:0] tw_chip,
    input wire logic [3:0] tw_addr,
    // Dialer control
    input wire logic dial_start,
    input wire logic [5:0] dial_port,
    input wire logic [2:0] dial_pattern,
    input wire logic dial_alt,
    input wire logic [4:0] pattern_grounded,
    input wire logic ctl_strobe,
    input wire logic [7:0] ctl_code,
    input wire logic conference_done,
    // Indicators
    output logic program_lamp,
    output logic tw_program_lamp,
    output logic load_done_indicator,
    output logic [3:0][6:0] readout_seg,
    output logic [3:0] check_digit,
    // Outpulsing
    output logic dial_seize,
    output logic [3:0] dial_digit,
    output logic dial_digit_valid
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Step one counter of the chain; bit 4 is the carry onward
    function automatic logic [4:0] ads_step(input logic [3:0] v, input logic inc,
        input logic [3:0] first, input logic [3:0] last);
        logic [4:0] r;
        r = {1'b0, v};
        if (inc)
        begin
            if (v == last)
                r = {1'b1, first};
            else
                r = {1'b0, v + 4'h1};
        end
        return r;
    endfunction

    function automatic logic [5:0] ads_port_num(input logic [3:0] tens, input logic [3:0] units);
        return 6'({2'b00, tens} * 6'h0A) + {2'b00, units};
    endfunction

    // Port 01..58 and memory 1..10 only; anything else writes nothing
    function automatic logic ads_sel_ok(input logic [5:0] port, input logic [3:0] mem);
        return port >= ads_pkg::ADS_PORT_FIRST && port <= ads_pkg::ADS_PORT_LAST
            && mem >= ads_pkg::ADS_MEM_FIRST && mem <= ads_pkg::ADS_MEM_LAST;
    endfunction

    // One cell per port, memory and bin; memories 6-10 are the alternates
    function automatic logic [13:0] ads_cell(input logic [5:0] port, input logic [3:0] mem,
        input logic [3:0] bin);
        return {port, 4'(mem - ads_pkg::ADS_MEM_FIRST), bin};
    endfunction

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    ads_pkg::ads_btn_t btn;
    ads_pkg::ads_lvl_t lvl;
    ads_pkg::ads_btn_t rise;

    // Buttons are taken as clean levels; contact bounce is filtered off-chip
    ads_sync #(
        .W($bits(ads_pkg::ads_btn_t) + $bits(ads_pkg::ads_lvl_t))
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pin_in({power_switch, master_reset_button, bin_button, memory_select_button,
            port_tens_button, port_units_button, key_strobe, program_switch,
            write_switch, dial_start, ctl_strobe, conference_done,
            key_code, thumbwheel_variant, blank_key, tw_port_tens, tw_port_units,
            tw_chip, tw_addr, dial_port, dial_pattern, dial_alt, pattern_grounded,
            ctl_code}),
        .sync_q({btn, lvl})
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ads_pkg::ads_btn_t btn_prev;
        ads_pkg::ads_sel_t sel;
        logic dark;
        logic prog_on;
        logic tw_prog;
        logic done_led;
        logic [3:0] check;
        ads_pkg::ads_dial_st_t dst;
        logic [5:0] dport;
        logic [3:0] dmem;
        logic [3:0] dbin;
        logic sent;
        logic [29:0] timer;
        logic [3:0] digit;
        logic dvalid;
        logic seize;
    } ads_state_t;

    ads_state_t q;
    ads_state_t d;
    logic [3:0] store_q [0:ads_pkg::ADS_STORE_DEPTH-1];
    logic wr_en;
    logic [13:0] wr_cell;
    logic [3:0] wr_data;
    logic [4:0] st_bin;
    logic [4:0] st_mem;
    logic [4:0] st_units;
    logic [4:0] st_tens;
    logic panel_write;
    logic tw_write_ev;
    logic [5:0] sel_port;
    logic [5:0] tw_port;
    logic [3:0] tw_mem;
    logic [3:0] scan_digit;
    logic stop_ev;
    logic panel_live;

    assign rise = btn & ~q.btn_prev;
    assign panel_live = q.prog_on && !lvl.variant;
    assign sel_port = ads_port_num(q.sel.tens, q.sel.units);
    assign panel_write = panel_live && rise.key && !rise.reset && ads_sel_ok(sel_port, q.sel.mem);
    assign tw_port = ads_port_num(lvl.tw_tens, lvl.tw_units);
    assign tw_mem = lvl.tw_chip;
    // Write on the write edge, or on a key while write is held down
    // Tens wheel above 5 would alias to a legal port once the sum is cut to six bits
    assign tw_write_ev = q.tw_prog && lvl.variant && (rise.tw_write || (rise.key && btn.tw_write))
        && lvl.tw_tens <= ads_pkg::ADS_TENS_LAST && lvl.tw_units <= ads_pkg::ADS_UNITS_LAST
        && ads_sel_ok(tw_port, tw_mem);
    assign scan_digit = store_q[ads_cell(q.dport, q.dmem, q.dbin)];
    assign stop_ev = (rise.ctl && lvl.ctl_code == ads_pkg::ADS_STOP_CODE) || rise.done;

    // ****************************************************************
    // Select chain and programming writes
    // ****************************************************************
    // A written digit counts like a bin press, so the chain tracks the card
    assign st_bin = ads_step(q.sel.bin, rise.bin || panel_write, ads_pkg::ADS_BIN_FIRST,
        ads_pkg::ADS_BIN_LAST);
    assign st_mem = ads_step(q.sel.mem, rise.mem || st_bin[4], ads_pkg::ADS_MEM_FIRST,
        ads_pkg::ADS_MEM_LAST);
    assign st_units = ads_step(q.sel.units, rise.units || st_mem[4], ads_pkg::ADS_UNITS_FIRST,
        ads_pkg::ADS_UNITS_LAST);
    assign st_tens = ads_step(q.sel.tens, rise.tens || st_units[4], ads_pkg::ADS_TENS_FIRST,
        ads_pkg::ADS_TENS_LAST);

    // Next state of panel, thumbwheel and dialer
    always_comb
    begin
        d = q;
        d.btn_prev = btn;
        d.dvalid = 1'b0;
        wr_en = 1'b0;
        wr_cell = ads_cell(sel_port, q.sel.mem, q.sel.bin);
        wr_data = lvl.key_code;
        if (rise.power)
            d.prog_on = ~q.prog_on;
        if (rise.tw_prog)
        begin
            d.tw_prog = ~q.tw_prog;
            d.done_led = 1'b0;
        end
        if (panel_live && rise.reset)
        begin
            d.sel.bin = ads_pkg::ADS_BIN_FIRST;
            d.sel.mem = ads_pkg::ADS_MEM_FIRST;
            d.sel.tens = ads_pkg::ADS_TENS_FIRST;
            d.sel.units = ads_pkg::ADS_UNITS_FIRST;
            d.dark = 1'b1;
        end
        else if (panel_live)
        begin
            d.sel = {st_bin[3:0], st_mem[3:0], st_tens[3:0], st_units[3:0]};
            if (rise.bin || rise.mem || rise.tens || rise.units || panel_write)
                d.dark = 1'b0;
            wr_en = panel_write;
        end
        else if (tw_write_ev)
        begin
            wr_en = 1'b1;
            wr_cell = ads_cell(tw_port, tw_mem, lvl.tw_addr);
            wr_data = lvl.blank ? ads_pkg::ADS_BLANK_CODE : lvl.key_code;
            if (lvl.tw_addr == ads_pkg::ADS_BIN_LAST)
                d.done_led = 1'b1;
        end
        d.check = store_q[ads_cell(sel_port, q.sel.mem, q.sel.bin)];
        // Outpulsing sequencer
        case (q.dst)
            ads_pkg::ADS_DIAL_IDLE:
            begin
                if (rise.dial_go && lvl.pattern < ads_pkg::ADS_PATTERNS
                    && !lvl.grounded[lvl.pattern])
                begin
                    d.dport = lvl.dport;
                    d.dmem = ads_pkg::ADS_MEM_FIRST + {1'b0, lvl.pattern}
                        + (lvl.alternate_number_set ? ads_pkg::ADS_ALT_OFFSET : 4'h0);
                    d.dst = ads_pkg::ADS_DIAL_SEIZE;
                    d.seize = 1'b1;
                end
            end
            ads_pkg::ADS_DIAL_SEIZE:
            begin
                d.dbin = ads_pkg::ADS_DIAL_BIN_FIRST;
                d.sent = 1'b0;
                d.dst = ads_pkg::ADS_DIAL_SCAN;
            end
            ads_pkg::ADS_DIAL_SCAN:
            begin
                if (scan_digit != ads_pkg::ADS_BLANK_CODE)
                begin
                    d.digit = scan_digit;
                    d.dvalid = 1'b1;
                    d.sent = 1'b1;
                end
                d.dbin = q.dbin + 4'h1;
                if (q.dbin == ads_pkg::ADS_DIAL_BIN_LAST)
                begin
                    d.timer = '0;
                    d.dst = (d.sent) ? ads_pkg::ADS_DIAL_HOLD : ads_pkg::ADS_DIAL_WAIT;
                end
            end
            ads_pkg::ADS_DIAL_WAIT:
            begin
                // Nothing went out: drop the line and try again later
                d.seize = 1'b0;
                d.timer = q.timer + 30'h1;
                if (q.timer == 30'(RETRY_CYCLES - 1))
                begin
                    d.dst = ads_pkg::ADS_DIAL_SEIZE;
                    d.seize = 1'b1;
                end
            end
            ads_pkg::ADS_DIAL_HOLD:
                d.seize = 1'b1;
            default:
                d.dst = ads_pkg::ADS_DIAL_IDLE;
        endcase
        if (stop_ev)
        begin
            d.dst = ads_pkg::ADS_DIAL_IDLE;
            d.seize = 1'b0;
        end
    end

    // State register; the store itself is not cleared by reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
            q.sel.mem <= ads_pkg::ADS_MEM_FIRST;
            q.dark <= 1'b1;
            q.dst <= ads_pkg::ADS_DIAL_IDLE;
        end
        else if (ce)
            q <= d;
    end

    // Digit store
    always_ff @(posedge clk_sys)
    begin
        if (ce && wr_en)
            store_q[wr_cell] <= wr_data;
    end

    // ****************************************************************
    // Readouts and outputs
    // ****************************************************************
    logic [3:0][3:0] readout_val;
    assign readout_val = {q.sel.units, q.sel.tens, q.sel.mem, q.sel.bin};

    // Readout 0 bin, 1 memory, 2 port tens, 3 port units
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_readout
            ads_hex_seg u_seg (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .value(readout_val[gi]),
                .dark(q.dark),
                .seg_q(readout_seg[gi])
            );
        end
    endgenerate

    assign program_lamp = q.prog_on;
    assign tw_program_lamp = q.tw_prog;
    assign load_done_indicator = q.done_led;
    assign check_digit = q.check;
    assign dial_seize = q.seize;
    assign dial_digit = q.digit;
    assign dial_digit_valid = q.dvalid;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !ce);

    sequence ads_empty_end;
        q.dst == ads_pkg::ADS_DIAL_SCAN && q.dbin == ads_pkg::ADS_DIAL_BIN_LAST && !d.sent
            && !stop_ev;
    endsequence

    bin_wrap_a: assert property (panel_live && !rise.reset && q.sel.bin == 4'hF && rise.bin
        |=> q.sel.bin == 4'h0 && q.sel.mem != $past(q.sel.mem)) else $error("bin wrap no carry");
    reset_dark_a: assert property (panel_live && rise.reset
        |=> q.dark && q.sel == {4'h0, 4'h1, 4'h0, 4'h0}) else $error("reset not blanked");
    first_units_a: assert property (panel_live && q.dark && q.sel == {4'h0, 4'h1, 4'h0, 4'h0}
        && rise.units && !rise.reset && !rise.bin && !rise.mem && !rise.tens && !panel_write
        |=> !q.dark && q.sel == {4'h0, 4'h1, 4'h0, 4'h1}) else $error("bad first port");
    chain_range_a: assert property (q.sel.units <= 4'h9 && q.sel.tens <= 4'h5
        && q.sel.mem >= 4'h1 && q.sel.mem <= 4'hA) else $error("counter out of range");
    write_step_a: assert property (panel_write && !rise.bin
        |=> q.sel.bin == 4'($past(q.sel.bin) + 4'h1)) else $error("bin not advanced");
    power_lamp_a: assert property (rise.power |=> program_lamp != $past(program_lamp))
        else $error("lamp not toggled");
    tw_lamp_a: assert property (rise.tw_prog |=> tw_program_lamp != $past(tw_program_lamp))
        else $error("program lamp not toggled");
    done_led_a: assert property (tw_write_ev && !panel_live && lvl.tw_addr == 4'hF
        && !rise.tw_prog |=> load_done_indicator) else $error("done indicator dark");
    skip_blank_a: assert property (dial_digit_valid |-> dial_digit != 4'hB)
        else $error("blank sent");
    empty_retry_a: assert property (ads_empty_end |=> q.dst == ads_pkg::ADS_DIAL_WAIT
        ##1 !dial_seize) else $error("empty port not released");
    stop_all_a: assert property (stop_ev |=> q.dst == ads_pkg::ADS_DIAL_IDLE && !dial_seize)
        else $error("dialer not stopped");
    grounded_a: assert property (q.dst == ads_pkg::ADS_DIAL_IDLE && rise.dial_go
        && lvl.pattern < 3'h5 && lvl.grounded[lvl.pattern] |=> !dial_seize)
        else $error("grounded pattern dialed");
endmodule

// File: verif/ads_panel_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Operator panel model: turns a one-cycle request into a press
// ****************************************************************
module ads_panel_model (
    // Clocking
    input wire logic clk_sys,
    // Requests and button pins
    input wire logic [10:0] req,
    output logic [10:0] btn
);
    logic [10:0] s1_q = 11'h000;
    logic [10:0] s2_q = 11'h000;
    // Stretch so the two-stage synchroniser always catches it
    always @(posedge clk_sys)
    begin
        s1_q <= req;
        s2_q <= s1_q;
    end
    assign btn = req | s1_q | s2_q;
endmodule

// File: verif/autodialer_number_store_programmer_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t value mismatch", $time); end end
// ****************************************************************
// Bench of the number store
// ****************************************************************
module autodialer_number_store_programmer_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [10:0] req = 11'h000;
    logic [10:0] btn;
    logic [3:0] key_code = 4'h0;
    logic variant = 1'b0;
    logic blank_key = 1'b0;
    logic [3:0] tw_t = 4'h0;
    logic [3:0] tw_u = 4'h1;
    logic [3:0] chip = 4'h1;
    logic [3:0] tw_addr = 4'h0;
    logic [5:0] dport = 6'h01;
    logic [2:0] pat = 3'h0;
    logic alternate_number_set = 1'b0;
    logic [4:0] gnd = 5'h00;
    logic [7:0] ctl_code = 8'h00;
    logic conf_done = 1'b0;
    logic program_lamp, tw_program_lamp, load_done_indicator, dial_seize, dial_digit_valid;
    logic [3:0][6:0] readout_seg;
    logic [3:0] check_digit, dial_digit;
    logic [3:0] mem [16];
    logic [3:0] got [$];
    int error_cnt = 0;
    int comparisons = 0;
    int seed_v;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    ads_panel_model pm_u (.clk_sys(clk_sys), .req(req), .btn(btn));
    ads_number_store #(.RETRY_CYCLES(20)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .power_switch(btn[0]), .master_reset_button(btn[1]), .bin_button(btn[2]),
        .memory_select_button(btn[3]), .port_tens_button(btn[4]),
        .port_units_button(btn[5]), .key_strobe(btn[6]), .key_code(key_code),
        .thumbwheel_variant(variant), .program_switch(btn[7]), .write_switch(btn[8]),
        .blank_key(blank_key), .tw_port_tens(tw_t), .tw_port_units(tw_u), .tw_chip(chip),
        .tw_addr(tw_addr), .dial_start(btn[9]), .dial_port(dport), .dial_pattern(pat),
        .dial_alt(alternate_number_set), .pattern_grounded(gnd), .ctl_strobe(btn[10]), .ctl_code(ctl_code),
        .conference_done(conf_done), .program_lamp(program_lamp),
        .tw_program_lamp(tw_program_lamp), .load_done_indicator(load_done_indicator),
        .readout_seg(readout_seg), .check_digit(check_digit), .dial_seize(dial_seize),
        .dial_digit(dial_digit), .dial_digit_valid(dial_digit_valid));

    // Expected segments gfedcba for a count, letters above nine
    function automatic logic [6:0] seg(input logic [3:0] v);
        logic [6:0] t [16];
        t = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
            7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
        return t[v];
    endfunction

    // Outpulsed digits are gathered mid-cycle, while the pulse stands
    always @(negedge clk_sys)
    begin
        if (dial_digit_valid === 1'b1)
            got.push_back(dial_digit);
    end

    // One press, then room for sync, state and readout latency
    task automatic press(input int i);
        @(negedge clk_sys) req[i] = 1'b1;
        @(negedge clk_sys) req[i] = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog so a stuck run still reaches the verdict
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("BAD %0t timeout", $time);
        wrap_up();
    end

    initial
    begin
        seed_v = $urandom(32'hdb619d41);
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        `CHK(program_lamp, 1'b0)
        `CHK(readout_seg, 28'h000_0000)
        press(0);
        `CHK(program_lamp, 1'b1)
        press(1);
        `CHK(readout_seg, 28'h000_0000)
        press(5);
        `CHK(readout_seg, {seg(4'h1), seg(4'h0), seg(4'h1), seg(4'h0)})
        $display("test reset and select done");
        // Load port 01: memory 1 random digits inside blanks, memory 2 all blank
        for (int b = 0; b < 32; b++)
        begin
            key_code = 4'($urandom % 15);
            if (key_code >= 4'hB)
                key_code = key_code + 4'h1;
            if (b == 0 || b >= 15)
                key_code = 4'hB;
            if (b < 16)
                mem[b] = key_code;
            press(6);
            `CHK(readout_seg[0], seg(4'(b + 1)))
        end
        `CHK(readout_seg[0], seg(4'h0))
        `CHK(readout_seg[1], seg(4'h3))
        $display("test key loading done");
        // Step back to the same memory and read each bin
        press(1);
        press(5);
        for (int b = 0; b < 16; b++)
        begin
            `CHK(check_digit, mem[b])
            press(2);
        end
        $display("test readback done");
        press(9);
        repeat (24) @(negedge clk_sys);
        `CHK(got.size(), 14)
        for (int i = 0; i < 14; i++)
            `CHK(got[i], mem[i + 1])
        `CHK(dial_seize, 1'b1)
        ctl_code = 8'h85;
        press(10);
        `CHK(dial_seize, 1'b0)
        gnd = 5'h01;
        press(9);
        repeat (24) @(negedge clk_sys);
        `CHK(dial_seize, 1'b0)
        // Pattern B of the same port still dials; its memory is all blank
        pat = 3'h1;
        press(9);
        repeat (14) @(negedge clk_sys);
        `CHK(dial_seize, 1'b0)
        `CHK(got.size(), 14)
        repeat (19) @(negedge clk_sys);
        `CHK(dial_seize, 1'b1)
        conf_done = 1'b1;
        repeat (8) @(negedge clk_sys);
        conf_done = 1'b0;
        `CHK(dial_seize, 1'b0)
        gnd = 5'h00;
        pat = 3'h0;
        $display("test dialing done");
        // Overwrite bin 14 of port 01 memory 1, then blank address 15
        variant = 1'b1;
        tw_addr = 4'hE;
        key_code = (mem[14] == 4'h7) ? 4'h3 : 4'h7;
        press(7);
        `CHK(tw_program_lamp, 1'b1)
        press(8);
        `CHK(load_done_indicator, 1'b0)
        tw_addr = 4'hF;
        blank_key = 1'b1;
        repeat (3) @(negedge clk_sys);
        press(8);
        `CHK(load_done_indicator, 1'b1)
        press(7);
        `CHK(tw_program_lamp, 1'b0)
        variant = 1'b0;
        press(1);
        press(5);
        repeat (14) press(2);
        `CHK(check_digit, key_code)
        $display("test thumbwheel done");
        wrap_up();
    end
endmodule
